//--- hdl/csq_defs.svh
`ifndef CSQ_DEFS_SVH
`define CSQ_DEFS_SVH

// Register map: each select owns a base word and a mask word
`define CSQ_SEL_STRIDE      8'h0C
`define CSQ_BASE_OFS        8'h00
`define CSQ_MASK_OFS        8'h04
`define CSQ_STATUS_OFS      8'hF0

// Mask register fields
`define CSQ_ADDR_MASK_HI    31
`define CSQ_ADDR_MASK_LO    16
`define CSQ_WP_BIT          8
`define CSQ_DMA_MASK_BIT    6
`define CSQ_CI_BIT          5
`define CSQ_SUP_CODE_BIT    4
`define CSQ_SUP_DATA_BIT    3
`define CSQ_USR_CODE_BIT    2
`define CSQ_USR_DATA_BIT    1
`define CSQ_V_BIT           0
`define CSQ_MASK_RW_BITS    32'hFFFF017F

// Base register fields
`define CSQ_BA_HI           31
`define CSQ_BA_LO           16

`endif

//--- hdl/csq_pkg.sv
package csq_pkg;
    typedef enum logic [2:0] {
        CSQ_SPACE_USR_DATA,
        CSQ_SPACE_USR_CODE,
        CSQ_SPACE_SUP_DATA,
        CSQ_SPACE_SUP_CODE,
        CSQ_SPACE_INTR,
        CSQ_SPACE_DMA
    } csq_space_type;
endpackage

//--- hdl/csq_decode.sv
`timescale 1ns/1ps
`include "csq_defs.svh"

module csq_decode
    import csq_pkg::*;
(
    input  wire logic [31:0] base_i,
    input  wire logic [31:0] mask_i,
    input  wire logic        boot_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        write_i,
    input  wire logic [5:0]  space_onehot_i,
    output logic             hit_o
);
    logic [15:0] care;
    logic        addr_match;
    logic        sel_ok;
    logic        space_ok;
    logic        wp_block;

    assign care       = ~mask_i[`CSQ_ADDR_MASK_HI:`CSQ_ADDR_MASK_LO];
    assign addr_match = ((addr_i[31:16] ^ base_i[`CSQ_BA_HI:`CSQ_BA_LO]) & care)
                        == 16'h0000;
    assign sel_ok     = mask_i[`CSQ_V_BIT] | boot_i;
    assign space_ok   = (space_onehot_i & mask_i[`CSQ_DMA_MASK_BIT:`CSQ_USR_DATA_BIT])
                        == 6'h00;
    assign wp_block   = write_i & mask_i[`CSQ_WP_BIT];
    assign hit_o      = addr_match & sel_ok & space_ok & ~wp_block;
endmodule

//--- hdl/csq_qualifier.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "csq_defs.svh"

// Behaviour
// - A write into a write-protected select's range leaves that select off, with no error.
// - Write-protect 0 allows reads and writes, 1 allows reads only.
// - A cleared space mask bit lets that access space activate the select.
// - A set space mask bit turns that space's access into a plain bus cycle with no select.
// - Mask bits 6 to 1 cover DMA, interrupt, supervisor code/data, user code/data.
// - A select other than select zero never asserts while its valid bit is 0; 1 enables it.
// - Select zero is the boot select and ignores the valid bit.
// - Reset clears every valid bit.
// - Decode compares the base address with core address bits 31 to 16.
// - A set base-address mask bit makes that address bit a don't-care.
module csq_qualifier
    import csq_pkg::*;
#(
    parameter int NUM_SEL = 5
) (
    input  wire logic               ref_clk_i,
    input  wire logic               nrst_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [31:0]        reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [31:0]        reg_rdata_o,
    input  wire logic               acc_valid_i,
    input  wire logic [31:0]        acc_addr_i,
    input  wire logic               acc_write_i,
    input  wire logic               acc_dma_i,
    input  wire logic               acc_intr_i,
    input  wire logic               acc_super_i,
    input  wire logic               acc_code_i,
    output logic      [NUM_SEL-1:0] chip_sel_o,
    output logic                    ext_cycle_o
);
    logic [31:0]        chip_select_base [NUM_SEL];
    logic [31:0]        chip_select_mask [NUM_SEL];
    logic [NUM_SEL-1:0] hit;
    logic [5:0]         space_onehot;
    logic [NUM_SEL-1:0] hit_seen;
    logic [31:0]        next_rdata;
    csq_space_type      space;

    function automatic logic [7:0] sel_ofs(input int idx, input logic [7:0] field);
        sel_ofs = 8'((idx * 12) & 8'hFF) + field;
    endfunction

    // Interrupt acknowledge and DMA take precedence over privilege and code/data
    always_comb begin
        if (acc_dma_i) begin
            space = CSQ_SPACE_DMA;
        end else if (acc_intr_i) begin
            space = CSQ_SPACE_INTR;
        end else if (acc_super_i) begin
            space = acc_code_i ? CSQ_SPACE_SUP_CODE : CSQ_SPACE_SUP_DATA;
        end else begin
            space = acc_code_i ? CSQ_SPACE_USR_CODE : CSQ_SPACE_USR_DATA;
        end
    end

    // One-hot aligned to mask bits 6..1
    always_comb begin
        space_onehot = 6'h00;
        unique case (space)
            CSQ_SPACE_DMA:      space_onehot[5] = 1'b1;
            CSQ_SPACE_INTR:     space_onehot[4] = 1'b1;
            CSQ_SPACE_SUP_CODE: space_onehot[3] = 1'b1;
            CSQ_SPACE_SUP_DATA: space_onehot[2] = 1'b1;
            CSQ_SPACE_USR_CODE: space_onehot[1] = 1'b1;
            CSQ_SPACE_USR_DATA: space_onehot[0] = 1'b1;
        endcase
    end

    // Base registers hold no reset value beyond zero
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                chip_select_base[i] <= 32'h00000000;
            end
        end else if (reg_wr_i) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                if (reg_addr_i == sel_ofs(i, `CSQ_BASE_OFS)) begin
                    chip_select_base[i] <= {reg_wdata_i[`CSQ_BA_HI:`CSQ_BA_LO], 16'h0000};
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                chip_select_mask[i] <= 32'h00000000;
            end
        end else if (reg_wr_i) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                if (reg_addr_i == sel_ofs(i, `CSQ_MASK_OFS)) begin
                    chip_select_mask[i] <= reg_wdata_i & `CSQ_MASK_RW_BITS;
                end
            end
        end
    end

    for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
        csq_decode u_dec (
            .base_i         (chip_select_base[g]),
            .mask_i         (chip_select_mask[g]),
            .boot_i         (g == 0),
            .addr_i         (acc_addr_i),
            .write_i        (acc_write_i),
            .space_onehot_i (space_onehot),
            .hit_o          (hit[g])
        );
    end

    // Selects registered one cycle after the access is presented
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chip_sel_o  <= '0;
            ext_cycle_o <= 1'b0;
        end else begin
            chip_sel_o  <= acc_valid_i ? hit : '0;
            ext_cycle_o <= acc_valid_i & (hit == '0);
        end
    end

    // Sticky record of which selects have fired, cleared by writing ones
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hit_seen <= '0;
        end else begin
            logic [NUM_SEL-1:0] clr;
            clr = '0;
            if (reg_wr_i && reg_addr_i == `CSQ_STATUS_OFS) begin
                clr = reg_wdata_i[NUM_SEL-1:0];
            end
            hit_seen <= (hit_seen & ~clr) | (acc_valid_i ? hit : '0);
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        for (int i = 0; i < NUM_SEL; i++) begin
            if (reg_addr_i == sel_ofs(i, `CSQ_BASE_OFS)) begin
                next_rdata = chip_select_base[i];
            end
            if (reg_addr_i == sel_ofs(i, `CSQ_MASK_OFS)) begin
                next_rdata = chip_select_mask[i];
            end
        end
        if (reg_addr_i == `CSQ_STATUS_OFS) begin
            next_rdata = 32'(hit_seen);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end
endmodule

//--- bench/csq_qualifier_asserts.sv
`timescale 1ns/1ps
module csq_qualifier_asserts #(
    parameter int NUM_SEL = 5
) (
    input wire logic               ref_clk_i,
    input wire logic               nrst_i,
    input wire logic [7:0]         reg_addr_i,
    input wire logic [31:0]        reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [31:0]        reg_rdata_o,
    input wire logic               acc_valid_i,
    input wire logic [31:0]        acc_addr_i,
    input wire logic               acc_write_i,
    input wire logic               acc_dma_i,
    input wire logic               acc_intr_i,
    input wire logic               acc_super_i,
    input wire logic               acc_code_i,
    input wire logic [NUM_SEL-1:0] chip_sel_o,
    input wire logic               ext_cycle_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic touched0;
    logic touched;
    // Reset setup holds until software writes a register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            touched0 <= 1'b0;
            touched  <= 1'b0;
        end else if (reg_wr_i) begin
            touched  <= 1'b1;
            touched0 <= touched0 | (reg_addr_i <= 8'h04);
        end
    end
    chk_sel_cause: assert property (chip_sel_o != '0 |-> $past(acc_valid_i))
        else $error("select without access");
    chk_one_outcome: assert property (acc_valid_i |=> (chip_sel_o != '0) != ext_cycle_o)
        else $error("access outcome wrong");
    chk_idle_quiet: assert property (!acc_valid_i |=> chip_sel_o == '0 && !ext_cycle_o)
        else $error("output without access");
    chk_invalid_off: assert property (!touched |-> chip_sel_o[NUM_SEL-1:1] == '0)
        else $error("invalid select asserted");
    chk_boot_hit: assert property (acc_valid_i && !touched0 && acc_addr_i[31:16] == 16'h0000
        |=> chip_sel_o[0]) else $error("boot select missed");
    chk_addr_miss: assert property (acc_valid_i && !touched && acc_addr_i[31:16] != 16'h0000
        |=> ext_cycle_o && chip_sel_o == '0) else $error("address miss selected");
    chk_wp_clear: assert property (acc_valid_i && acc_write_i && !touched0 &&
        acc_addr_i[31:16] == 16'h0000 |=> chip_sel_o[0]) else $error("write refused");
    chk_ext_single: assert property (ext_cycle_o |-> $past(acc_valid_i) && chip_sel_o == '0)
        else $error("external cycle wrong");
    cover property (chip_sel_o[1]);
    cover property (ext_cycle_o && touched);
    cover property (acc_valid_i && acc_write_i ##1 ext_cycle_o);
endmodule

//--- bench/csq_mem_model.sv
`timescale 1ns/1ps
module csq_mem_model #(
    parameter int NUM_SEL = 5
) (
    input  wire logic               ref_clk_i,
    input  wire logic [NUM_SEL-1:0] chip_sel_i,
    output logic      [NUM_SEL-1:0] last_sel_o
);
    // Memory answers only when selected; remember which one answered last
    always_ff @(posedge ref_clk_i) begin
        if (chip_sel_i != '0) begin
            last_sel_o <= chip_sel_i;
        end
    end
endmodule

//--- bench/chip_select_access_qualifier_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module chip_select_access_qualifier_tb;
    import csq_pkg::*;
    localparam int         NUM_SEL = 5;
    localparam logic [3:0] SPACE [1:6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic                  ref_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic                  acc_valid_i = 1'b0, acc_write_i = 1'b0, ext_cycle_o;
    logic                  acc_dma_i = 1'b0, acc_intr_i = 1'b0, acc_super_i = 1'b0, acc_code_i = 1'b0;
    logic [7:0]            reg_addr_i = 8'h00;
    logic [31:0]           reg_wdata_i = 32'h0, acc_addr_i = 32'h0, reg_rdata_o;
    logic [NUM_SEL-1:0]    chip_sel_o, last_sel;
    int                    failures = 0, comparisons = 0;
    csq_qualifier #(.NUM_SEL(NUM_SEL)) u_dut (.*);
    csq_mem_model #(.NUM_SEL(NUM_SEL)) u_mem (.ref_clk_i(ref_clk_i), .chip_sel_i(chip_sel_o),
        .last_sel_o(last_sel));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK("read", e, reg_rdata_o)
    endtask
    task automatic acc(input logic [31:0] a, input logic w, input logic [3:0] at,
                       input logic [NUM_SEL-1:0] es);
        @(posedge ref_clk_i);
        {acc_valid_i, acc_write_i, acc_addr_i} <= {1'b1, w, a};
        {acc_dma_i, acc_intr_i, acc_super_i, acc_code_i} <= at;
        @(posedge ref_clk_i);
        acc_valid_i <= 1'b0;
        #1;
        `CHK("select", es, chip_sel_o)
        `CHK("external", es == '0, ext_cycle_o)
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        failures++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd(8'h10, 32'h0);
        rd(8'hC0, 32'h0);
        acc(32'h00001234, 1'b1, 4'h0, 5'h01);
        acc(32'h00011234, 1'b0, 4'h8, 5'h00);
        wr(8'h0C, 32'h80000000);
        wr(8'h10, 32'h00030000);
        acc(32'h80020000, 1'b0, 4'h0, 5'h00);
        wr(8'h10, 32'h00030001);
        rd(8'h10, 32'h00030001);
        acc(32'h80030000, 1'b0, 4'h0, 5'h02);
        acc(32'h80040000, 1'b0, 4'h0, 5'h00);
        for (int b = 1; b <= 6; b++) begin
            wr(8'h10, 32'h00030001 | (32'h1 << b));
            acc(32'h80000000, 1'b0, SPACE[b], 5'h00);
            acc(32'h80000000, 1'b0, SPACE[b == 1 ? 2 : 1], 5'h02);
        end
        wr(8'h10, 32'h00030101);
        acc(32'h80010000, 1'b0, 4'h3, 5'h02);
        acc(32'h80010000, 1'b1, 4'h3, 5'h00);
        wr(8'h10, 32'h00030001);
        acc(32'h80010000, 1'b1, 4'h3, 5'h02);
        `CHK("memory", 5'h02, last_sel)
        rd(8'hF0, 32'h00000003);
        wr(8'hF0, 32'h00000001);
        rd(8'hF0, 32'h00000002);
        finish_test();
    end
endmodule
bind csq_qualifier csq_qualifier_asserts #(.NUM_SEL(NUM_SEL)) u_chk (.*);
